// file: hw/tmc_pkg.sv
// Package of constants and types for the 16-bit timer/counter core.
package tmc_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PRESC_W = 3;
  localparam int unsigned CS_W = 5;

  // Clock source select codes.
  localparam logic [4:0] CS_INSTR = 5'h00;
  localparam logic [4:0] CS_FOSC = 5'h01;
  localparam logic [4:0] CS_EXT_PIN = 5'h02;
  localparam logic [4:0] CS_SEC_OSC = 5'h03;
  localparam logic [4:0] CS_ALT_SRC = 5'h04;

  // The instruction cycle is four system clocks.
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [15:0] FOSC_STEP = 16'h0004;
  localparam logic [15:0] UNIT_STEP = 16'h0001;

  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] HIBUF_RST = 8'h00;
  localparam logic [2:0] PRESC_RST = 3'h0;

  typedef struct packed {
    logic run_enable;
    logic gate_count_enable;
    logic gate_polarity;
    logic sync_bypass;
    logic wide_access_enable;
    logic [1:0] prescale_select;
    logic [4:0] clock_select;
  } tmc_ctrl_t;

  typedef struct packed {
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic rd_high;
    logic [7:0] wdata;
  } tmc_sw_t;

endpackage

// file: hw/tmc_prescaler.sv
// Divide-by-1/2/4/8 prescaler producing one-cycle advance pulses.
`timescale 1ns/100ps
module tmc_prescaler (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [1:0] i_prescale_select,
  // Result
  output logic o_advance
);
  logic [tmc_pkg::PRESC_W-1:0] presc_q;
  logic [tmc_pkg::PRESC_W-1:0] mask;

  always_comb begin
    mask = 3'((4'h1 << i_prescale_select) - 4'h1);
    o_advance = i_tick && ((presc_q & mask) == mask);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_q <= tmc_pkg::PRESC_RST;
    end else if (i_clear) begin
      presc_q <= tmc_pkg::PRESC_RST;
    end else if (i_tick) begin
      presc_q <= presc_q + 3'h1;
    end
  end
endmodule // tmc_prescaler

// file: hw/tmc_sync2.sv
// Two-stage synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
module tmc_sync2 (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Level
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // tmc_sync2

// file: hw/tmc_timer16_core.sv
// Top of the 16-bit timer/counter core with gate, prescaler and buffered access.
`timescale 1ns/100ps
module tmc_timer16_core (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  input wire tmc_pkg::tmc_ctrl_t i_ctrl,
  input wire logic i_sleep,
  // Software byte access
  input wire tmc_pkg::tmc_sw_t i_sw,
  output logic [7:0] o_rdata,
  // Count sources and gate
  input wire logic i_external_count_input,
  input wire logic i_sec_osc,
  input wire logic i_alt_source,
  input wire logic i_gate_input,
  // Status
  output logic [15:0] o_count,
  output logic o_overflow_flag,
  input wire logic i_overflow_clear
);

  // Sources derived from the system clock stop with it while the device sleeps.
  function automatic logic fn_is_internal(input logic [4:0] cs);
    return (cs == tmc_pkg::CS_INSTR) || (cs == tmc_pkg::CS_FOSC);
  endfunction

  // The full-rate source advances by a whole instruction's worth of counts.
  function automatic logic [15:0] fn_step(input logic [4:0] cs);
    return (cs == tmc_pkg::CS_FOSC) ? tmc_pkg::FOSC_STEP : tmc_pkg::UNIT_STEP;
  endfunction

  // Pin synchronisers; the bypass path is also sampled twice since this core has one clock.
  logic ext_s;
  logic sosc_s;
  logic alt_s;
  logic gate_s;

  tmc_sync2 u_sync_ext (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_external_count_input),
    .o_sync(ext_s)
  );
  tmc_sync2 u_sync_sosc (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_sec_osc),
    .o_sync(sosc_s)
  );
  tmc_sync2 u_sync_alt (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_alt_source),
    .o_sync(alt_s)
  );
  tmc_sync2 u_sync_gate (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_gate_input),
    .o_sync(gate_s)
  );

  // Instruction-cycle divider: one pulse every four system clocks.
  logic [1:0] instr_div_q;
  logic instr_tick;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      instr_div_q <= 2'h0;
    end else begin
      instr_div_q <= instr_div_q + 2'h1;
    end
  end

  assign instr_tick = (instr_div_q == tmc_pkg::INSTR_DIV_LAST);

  // Source selection.
  logic src_level;
  logic src_is_clock;
  logic src_is_ext;

  always_comb begin
    src_level = 1'b0;
    src_is_ext = 1'b0;
    case (i_ctrl.clock_select)
      tmc_pkg::CS_INSTR: src_level = 1'b0;
      tmc_pkg::CS_FOSC: src_level = 1'b0;
      tmc_pkg::CS_EXT_PIN: begin
        src_level = ext_s;
        src_is_ext = 1'b1;
      end
      tmc_pkg::CS_SEC_OSC: src_level = sosc_s;
      tmc_pkg::CS_ALT_SRC: src_level = alt_s;
      default: src_level = 1'b0;
    endcase
  end

  assign src_is_clock = fn_is_internal(i_ctrl.clock_select);

  // Write decode shared by the counter, the prescaler and the falling-edge arm.
  logic wr_any;
  logic wr_high_live;
  assign wr_any = i_sw.wr_low || i_sw.wr_high;
  assign wr_high_live = i_sw.wr_high && !i_ctrl.wide_access_enable;

  // Edge detection on the selected source, with the falling-edge arm for counter mode.
  logic src_prev_q;
  logic armed_q;
  logic rise;
  logic fall;
  logic [4:0] cs_q;
  logic cs_changed;

  // A source switch is not an edge: the first cycle on a new source only records its level.
  assign cs_changed = (i_ctrl.clock_select != cs_q);
  assign rise = src_level && !src_prev_q && !cs_changed;
  assign fall = !src_level && src_prev_q && !cs_changed;

  // The select is a same-domain level, so one register is enough to see it change.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_q <= tmc_pkg::CS_INSTR;
    end else begin
      cs_q <= i_ctrl.clock_select;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // Any counter write or disable disarms until a falling edge is seen.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed_q <= 1'b0;
    end else if (wr_any || !i_ctrl.run_enable) begin
      armed_q <= 1'b0;
    end else if (fall) begin
      armed_q <= 1'b1;
    end
  end

  // Enable and gate decode.
  logic gate_active;
  logic count_en;

  assign gate_active = (gate_s == i_ctrl.gate_polarity);

  always_comb begin
    // A clear run bit stops the count whatever the gate does.
    case ({i_ctrl.run_enable, i_ctrl.gate_count_enable})
      2'b11: count_en = gate_active;
      2'b10: count_en = 1'b1;
      default: count_en = 1'b0;
    endcase
  end

  // Sources derived from the system clock halt in sleep; bypass mode with a pin or an
  // oscillator source keeps running and can still wake the processor on rollover.
  // Bypass only changes this sleep behaviour, so a mode switch loses or adds no count.
  logic sleep_ok;
  assign sleep_ok = !i_sleep || (i_ctrl.sync_bypass && !src_is_clock);

  logic tick;
  always_comb begin
    if (src_is_clock) begin
      tick = count_en && sleep_ok && instr_tick;
    end else if (src_is_ext) begin
      tick = count_en && sleep_ok && rise && (armed_q || fall);
    end else begin
      tick = count_en && sleep_ok && rise;
    end
  end

  // Prescaler: low byte write clears it; high byte write clears it only in byte mode.
  logic presc_clear;
  logic advance;

  assign presc_clear = i_sw.wr_low || wr_high_live;

  tmc_prescaler u_presc (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(presc_clear),
    .i_tick(tick),
    .i_prescale_select(i_ctrl.prescale_select),
    .o_advance(advance)
  );

  // Counter and high-byte buffer.
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] step;
  logic [7:0] hibuf_q;
  logic wrap;

  assign step = fn_step(i_ctrl.clock_select);
  // Rollover past all ones, including the four-count step.
  assign wrap = advance && ({1'b0, cnt_q} + {1'b0, step} > 17'h0ffff);

  always_comb begin
    cnt_d = cnt_q;
    if (advance) begin
      cnt_d = cnt_q + step;
    end
    // A write beats a coincident increment so software sees what it wrote.
    if (i_sw.wr_low) begin
      if (i_ctrl.wide_access_enable) begin
        cnt_d = {hibuf_q, i_sw.wdata};
      end else begin
        cnt_d = {cnt_q[15:8], i_sw.wdata};
      end
    end else if (wr_high_live) begin
      cnt_d = {i_sw.wdata, cnt_q[7:0]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= tmc_pkg::CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // In byte mode the buffer is left alone, so wide mode resumes from the last snapshot.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hibuf_q <= tmc_pkg::HIBUF_RST;
    end else if (i_ctrl.wide_access_enable) begin
      if (i_sw.wr_high) begin
        hibuf_q <= i_sw.wdata;
      end else if (i_sw.rd_low) begin
        hibuf_q <= cnt_q[15:8];
      end
    end
  end

  // Read data is registered one byte per read; only wide mode returns the high byte from the low-read snapshot.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_sw.rd_low) begin
      o_rdata <= cnt_q[7:0];
    end else if (i_sw.rd_high) begin
      o_rdata <= i_ctrl.wide_access_enable ? hibuf_q : cnt_q[15:8];
    end
  end

  // The count output registers the next value, so it always equals the counter.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= tmc_pkg::CNT_RST;
    end else begin
      o_count <= cnt_d;
    end
  end

  // Overflow flag: a rollover in the clearing cycle wins over the clear. It is also what
  // wakes a sleeping processor, so every rollover sets it, whichever source drove it.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow_flag <= 1'b0;
    end else if (wrap) begin
      o_overflow_flag <= 1'b1;
    end else if (i_overflow_clear) begin
      o_overflow_flag <= 1'b0;
    end
  end

endmodule // tmc_timer16_core

// file: sim/tb_timer16_counter_core.sv
// Self-checking bench for the timer/counter core.
`timescale 1ns/100ps
module tb_timer16_counter_core;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tmc_pkg::tmc_ctrl_t ctrl = '0;
  tmc_pkg::tmc_sw_t sw = '0;
  logic sleep = 1'b0;
  logic gate = 1'b0;
  logic ov_clr = 1'b0;
  logic src_en = 1'b0;
  logic [2:0] lvl;
  logic [7:0] rdata;
  logic [15:0] count;
  logic flag;
  logic [15:0] v;
  logic [1:0] p;
  logic [7:0] b[3];
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;

  initial begin
    forever #2 clk = ~clk;
  end
  tmc_src_model u_src (.i_clk_sys(clk), .i_rst_n(rst_n), .i_en(src_en), .o_lvl(lvl));
  tmc_timer16_core uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ctrl(ctrl), .i_sleep(sleep),
    .i_sw(sw), .o_rdata(rdata), .i_external_count_input(lvl[0]), .i_sec_osc(lvl[1]),
    .i_alt_source(lvl[2]), .i_gate_input(gate), .o_count(count), .o_overflow_flag(flag),
    .i_overflow_clear(ov_clr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [3:0] st, input logic [7:0] d);
    @(posedge clk);
    sw <= {st, d};
  endtask
  task automatic rd(input logic [3:0] st, output logic [7:0] d);
    put(st, 8'h00);
    put(4'h0, 8'h00);
    #1;
    d = rdata;
  endtask
  task automatic setc(input logic [4:0] f, input logic [1:0] ps, input logic [4:0] cs);
    @(posedge clk);
    ctrl <= {f, ps, cs};
    #1;
  endtask
  function automatic logic in_window(input logic [15:0] x, input logic [15:0] lo,
    input logic [15:0] hi);
    return (x >= lo) && (x <= hi);
  endfunction
  function automatic int exp_gap(input logic [4:0] cs, input logic [1:0] ps);
    int base;
    base = (cs == tmc_pkg::CS_EXT_PIN) ? 6 : (cs == tmc_pkg::CS_SEC_OSC) ? 10 :
      (cs == tmc_pkg::CS_ALT_SRC) ? 8 : 4;
    return base << ps;
  endfunction
  // The first changes after a mode switch may be irregular, so only the third gap is judged.
  task automatic gap(input logic [4:0] cs);
    logic [15:0] c0;
    int n;
    repeat (3) begin
      c0 = count;
      n = 0;
      do begin
        tick(1);
        n++;
      end while (count === c0 && n < 400);
    end
    check(n, exp_gap(cs, ctrl.prescale_select));
    check(count - c0, (cs == tmc_pkg::CS_FOSC) ? 4 : 1);
  endtask
  task automatic held(input int n);
    tick(6);
    v = count;
    tick(n);
    check(count, v);
  endtask
  task automatic give_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    v = 16'($urandom(9221));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    src_en <= 1'b1;
    tick(1);
    check(count, 16'h0000);
    check(flag, 1'b0);
    for (int cs = 0; cs < 5; cs++) begin
      p = 2'($urandom);
      setc(5'h10, p, cs[4:0]);
      gap(cs[4:0]);
    end
    p[0] = 1'($urandom);
    gate <= ~p[0];
    setc({2'b11, p[0], 2'b00}, 2'h0, tmc_pkg::CS_INSTR);
    held(40);
    gate <= p[0];
    gap(tmc_pkg::CS_INSTR);
    sleep <= 1'b1;
    setc(5'h10, 2'h0, tmc_pkg::CS_INSTR);
    held(40);
    setc(5'h12, 2'h0, tmc_pkg::CS_EXT_PIN);
    gap(tmc_pkg::CS_EXT_PIN);
    sleep <= 1'b0;
    setc(5'h00, 2'h0, tmc_pkg::CS_INSTR);
    v = 16'($urandom);
    put(4'b0100, v[15:8]);
    put(4'b1000, v[7:0]);
    put(4'h0, 8'h00);
    tick(2);
    check(count, v);
    setc(5'h01, 2'h0, tmc_pkg::CS_INSTR);
    put(4'b0100, ~v[15:8]);
    put(4'h0, 8'h00);
    tick(2);
    check(count, v);
    put(4'b0100, 8'h12);
    put(4'b1000, 8'hfe);
    put(4'b0010, 8'h00);
    put(4'b0001, 8'h00);
    put(4'h0, 8'h00);
    tick(1);
    check(count, 16'h12fe);
    check(rdata, 8'h12);
    setc(5'h11, 2'h0, tmc_pkg::CS_INSTR);
    tick(40);
    put(4'b0001, 8'h00);
    put(4'h0, 8'h00);
    tick(1);
    check(rdata, 8'h12);
    setc(5'h10, 2'h0, tmc_pkg::CS_INSTR);
    put(4'b0001, 8'h00);
    put(4'h0, 8'h00);
    tick(1);
    check(rdata, 8'h13);
    setc(5'h00, 2'h0, tmc_pkg::CS_INSTR);
    put(4'b0100, 8'hff);
    put(4'b1000, 8'hfe);
    put(4'h0, 8'h00);
    setc(5'h10, 2'h0, tmc_pkg::CS_INSTR);
    tick(30);
    check(flag, 1'b1);
    check(count[15:5], 11'h000);
    @(posedge clk);
    ov_clr <= 1'b1;
    @(posedge clk);
    ov_clr <= 1'b0;
    tick(2);
    check(flag, 1'b0);
    setc(5'h00, 2'h0, tmc_pkg::CS_INSTR);
    put(4'b0100, 8'h01);
    put(4'b1000, 8'hfe);
    put(4'h0, 8'h00);
    setc(5'h10, 2'h0, tmc_pkg::CS_INSTR);
    rd(4'b0001, b[0]);
    rd(4'b0010, b[1]);
    rd(4'b0001, b[2]);
    // A changed high byte means the low byte may belong to the older value.
    if (b[0] !== b[2]) begin
      rd(4'b0010, b[1]);
    end
    check(in_window({b[2], b[1]}, 16'h01fe, 16'h0204), 1'b1);
    give_verdict();
  end
endmodule // tb_timer16_counter_core

// file: sim/tmc_core_checker_assertions.sv
// Concurrent checks on the ports of the timer/counter core.
`timescale 1ns/100ps
module tmc_core_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Watched ports
  input wire tmc_pkg::tmc_ctrl_t i_ctrl,
  input wire tmc_pkg::tmc_sw_t i_sw,
  input wire logic i_overflow_clear,
  input wire logic [7:0] o_rdata,
  input wire logic [15:0] o_count,
  input wire logic o_overflow_flag
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  a_stop_holds: assert property (!i_ctrl.run_enable && !i_sw.wr_low && !i_sw.wr_high
    |=> $stable(o_count)) else $error("count moved while stopped");
  a_low_write: assert property (!i_ctrl.wide_access_enable && i_sw.wr_low
    |=> o_count[7:0] == $past(i_sw.wdata)) else $error("low byte write lost");
  a_wide_load: assert property (i_ctrl.wide_access_enable && i_sw.wr_high ##1
    i_ctrl.wide_access_enable && i_sw.wr_low
    |=> o_count == {$past(i_sw.wdata, 2), $past(i_sw.wdata)}) else $error("wide load wrong");
  a_high_buffered: assert property (i_ctrl.wide_access_enable && i_sw.wr_high
    && !i_sw.wr_low && !i_ctrl.run_enable |=> $stable(o_count)) else $error("high write live");
  a_read_low: assert property (i_sw.rd_low
    |=> o_rdata == $past(o_count[7:0])) else $error("low read wrong");
  a_read_buffer: assert property (i_ctrl.wide_access_enable && i_sw.rd_low && !i_sw.wr_high
    ##1 i_ctrl.wide_access_enable && i_sw.rd_high && !i_sw.rd_low && !i_sw.wr_high
    |=> o_rdata == $past(o_count[15:8], 2)) else $error("buffered high read wrong");
  a_flag_sticky: assert property (o_overflow_flag && !i_overflow_clear
    |=> o_overflow_flag) else $error("flag dropped");
  a_wrap_flag: assert property (o_count == 16'hffff && !i_sw.wr_low && !i_sw.wr_high
    ##1 o_count == 16'h0000 |-> ##[0:1] o_overflow_flag) else $error("wrap without flag");
endmodule // tmc_core_checker

bind tmc_timer16_core tmc_core_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_ctrl(i_ctrl), .i_sw(i_sw), .i_overflow_clear(i_overflow_clear), .o_rdata(o_rdata),
  .o_count(o_count), .o_overflow_flag(o_overflow_flag));

// file: sim/tmc_src_model.sv
// Far-side model: external pin, secondary oscillator and alternate source.
`timescale 1ns/100ps
module tmc_src_model #(
  parameter int EXT_H = 3,
  parameter int SEC_H = 5,
  parameter int ALT_H = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control and levels
  input wire logic i_en,
  output logic [2:0] o_lvl
);
  localparam int HALF[3] = '{EXT_H, SEC_H, ALT_H};
  int n[3];
  // Sources stand still low when disabled, so no stray edge enters between runs.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    for (int k = 0; k < 3; k++) begin
      if (!i_rst_n || !i_en) begin
        o_lvl[k] <= 1'b0;
        n[k] <= 0;
      end else if (n[k] + 1 == HALF[k]) begin
        o_lvl[k] <= ~o_lvl[k];
        n[k] <= 0;
      end else begin
        n[k] <= n[k] + 1;
      end
    end
  end
endmodule // tmc_src_model
